// ### src/ll_debug_pkg.sv
// Package for the link-layer debug and error-status register group.
// Assumes a single 100 MHz core clock and an AHB-Lite register bus.
package ll_debug_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [31:0] DIAG_MIRROR_ADDR = 32'h4000_0054;
   localparam logic [31:0] ZONE_UPPER_ADDR  = 32'h4000_0058;
   localparam logic [31:0] ZONE_LOWER_ADDR  = 32'h4000_005c;
   localparam logic [31:0] ERROR_FLAGS_ADDR = 32'h4000_0060;
   localparam logic [31:0] REG_RESET        = 32'h0000_0000;

   // -------------------------------------------------------------
   // Field layout
   // -------------------------------------------------------------
   localparam int LIMIT_W       = 16;
   localparam int DIAG_W        = 8;
   localparam int NUM_ERR       = 18;
   localparam int ERR_STACKED   = 17;
   localparam int ERR_RXBUF     = 16;
   localparam int ERR_TXBUF     = 15;
   localparam int ERR_RXDESC    = 14;
   localparam int ERR_TXDESC    = 13;
   localparam int ERR_FORMAT    = 12;
   localparam int ERR_CHMAP     = 11;
   localparam int ERR_ADVGAP    = 10;
   localparam int ERR_IFSGAP    = 9;
   localparam int ERR_ALLOW     = 8;
   localparam int ERR_EVPREF    = 7;
   localparam int ERR_SCPREF    = 6;
   localparam int ERR_ENTRY     = 5;
   localparam int ERR_SCXMEM    = 4;
   localparam int ERR_RADXMEM   = 3;
   localparam int ERR_PKTXMEM   = 2;
   localparam int ERR_DECRYPT   = 1;
   localparam int ERR_ENCRYPT   = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [DIAG_W-1:0] bus3;
      logic [DIAG_W-1:0] bus2;
      logic [DIAG_W-1:0] bus1;
      logic [DIAG_W-1:0] bus0;
   } diag_buses_t;

   typedef struct packed {
      logic [LIMIT_W-1:0] register_zone;
      logic [LIMIT_W-1:0] xmem_zone;
   } zone_limits_t;

   // Raw one-cycle error events from the controller blocks
   typedef struct packed {
      logic stacked_event_irq;
      logic rx_buffer_null;
      logic tx_buffer_null;
      logic rx_descriptor_null;
      logic tx_descriptor_null;
      logic bad_structure_format;
      logic channel_map_mismatch;
      logic advertising_gap_short;
      logic interframe_gap_short;
      logic allow_list_timeout;
      logic event_ctrl_prefetch;
      logic scheduler_prefetch;
      logic scheduler_entry_timing;
      logic scheduler_xmem_late;
      logic radio_xmem_late;
      logic packet_xmem_late;
      logic decrypt_late;
      logic encrypt_late;
   } error_events_t;

endpackage

// ### src/ll_debug_regs.sv
// Debug mirror, zone limits and sticky error flags of the link-layer core.
// Assumes one AHB-Lite master, error events synchronous to i_mclk.
//
// Function
// RULE1: Mirror four debug buses, bus three on top
// RULE2: Upper limit register holds register-zone upper half
// RULE3: Upper limit register holds memory-zone lower half
// RULE4: Lower limit register holds register-zone upper half
// RULE5: Lower limit register holds memory-zone lower half
// RULE6: Flag unacknowledged stacked event interrupts
// RULE7: Flag null receive buffer pointer
// RULE8: Flag null transmit buffer pointer
// RULE9: Flag null receive descriptor pointer
// RULE10: Flag null transmit descriptor pointer
// RULE11: Flag invalid control structure format
// RULE12: Flag channel map count mismatch at hopping
// RULE13: Flag advertising interval underrun
// RULE14: Flag inter-frame space underrun
// RULE15: Flag allow-list parsing timeout
// RULE16: Flag both prefetch errors on late event
// RULE17: Flag invalid consecutive table entry timing
// RULE18: Flag late scheduler exchange memory access
// RULE19: Flag late radio exchange memory access
// RULE20: Flag late packet exchange memory access
// RULE21: Flag late block decryption
// RULE22: Flag late block encryption
// RULE23: Zone hits inclusive of both limits
// RULE24: Flags sticky until reset, writes ignored
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ll_debug_regs
   import ll_debug_pkg::*;
(
   input  wire logic                              i_mclk,
   input  wire logic                              i_nrst,
   // AHB-Lite slave
   input  wire logic                              i_hsel,
   input  wire logic [31:0]                       i_haddr,
   input  wire logic [1:0]                        i_htrans,
   input  wire logic                              i_hwrite,
   input  wire logic [2:0]                        i_hsize,
   input  wire logic [31:0]                       i_hwdata,
   input  wire logic                              i_hready,
   output logic      [31:0]                       o_hrdata,
   output logic                                   o_hreadyout,
   output logic                                   o_hresp,
   // Core side
   input  wire ll_debug_pkg::diag_buses_t         i_diag_buses,
   input  wire ll_debug_pkg::error_events_t       i_error_events,
   input  wire logic [ll_debug_pkg::LIMIT_W-1:0]  i_register_access_addr,
   input  wire logic [ll_debug_pkg::LIMIT_W-1:0]  i_xmem_access_addr,
   output logic                                   o_register_zone_hit,
   output logic                                   o_xmem_zone_hit,
   output ll_debug_pkg::error_events_t            o_error_flags
);
   import ll_debug_pkg::*;

   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic        wr_pend_ff;
   logic        rd_pend_ff;
   logic [31:0] addr_ff;
   logic        take;

   assign take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= REG_RESET;
      end else if (i_hready) begin
         wr_pend_ff <= take && i_hwrite;
         rd_pend_ff <= take && !i_hwrite;
         addr_ff    <= i_haddr;
      end
   end

   // Zero wait states; every access, mapped or not, answers OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp     = HRESP_OKAY;

   // ----------------------------------------------------------------
   // Zone limit registers
   // ----------------------------------------------------------------
   zone_limits_t upper_ff;
   zone_limits_t lower_ff;

   // Size is not decoded; every write lands as a whole word
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         upper_ff <= REG_RESET;
      end else if (wr_pend_ff && addr_ff == ZONE_UPPER_ADDR) begin
         upper_ff <= i_hwdata; // RULE2 RULE3
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         lower_ff <= REG_RESET;
      end else if (wr_pend_ff && addr_ff == ZONE_LOWER_ADDR) begin
         lower_ff <= i_hwdata; // RULE4 RULE5
      end
   end

   // ----------------------------------------------------------------
   // Zone hit flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_register_zone_hit <= 1'b0;
         o_xmem_zone_hit     <= 1'b0;
      end else begin
         o_register_zone_hit <= (i_register_access_addr >= lower_ff.register_zone) &&
                                (i_register_access_addr <= upper_ff.register_zone); // RULE23
         o_xmem_zone_hit     <= (i_xmem_access_addr >= lower_ff.xmem_zone) &&
                                (i_xmem_access_addr <= upper_ff.xmem_zone); // RULE23
      end
   end

   // ----------------------------------------------------------------
   // Sticky error flags
   // ----------------------------------------------------------------
   // No software clear exists, so an event can never race a clear
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_error_flags <= '0;
      end else begin
         o_error_flags <= o_error_flags | i_error_events; // RULE24
      end
   end
   // Each event bit lands at its own position: RULE6 RULE7 RULE8 RULE9
   // RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16 RULE17 RULE18
   // RULE19 RULE20 RULE21 RULE22

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = REG_RESET;
      case (i_haddr)
         DIAG_MIRROR_ADDR: nxt_rdata = i_diag_buses; // RULE1
         ZONE_UPPER_ADDR:  nxt_rdata = upper_ff;
         ZONE_LOWER_ADDR:  nxt_rdata = lower_ff;
         ERROR_FLAGS_ADDR: nxt_rdata = {{(32-NUM_ERR){1'b0}}, o_error_flags};
         default:          nxt_rdata = REG_RESET;
      endcase
   end

   // Sampled at address phase so read data stands in the data phase
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hrdata <= REG_RESET;
      end else if (take && !i_hwrite) begin
         o_hrdata <= nxt_rdata;
      end
   end

endmodule

// ### dv/ll_debug_regs_sva.sv
// Checker: register readback, zone hit and sticky error flags.
// Assumes it is bound into ll_debug_regs and sees only its ports.
`timescale 1ns/1ps
module ll_debug_regs_sva
   import ll_debug_pkg::*;
(
   input wire logic                        i_mclk,
   input wire logic                        i_nrst,
   input wire logic                        i_hsel,
   input wire logic [31:0]                 i_haddr,
   input wire logic [1:0]                  i_htrans,
   input wire logic                        i_hwrite,
   input wire logic [31:0]                 i_hwdata,
   input wire logic                        i_hready,
   input wire logic [31:0]                 o_hrdata,
   input wire ll_debug_pkg::diag_buses_t   i_diag_buses,
   input wire ll_debug_pkg::error_events_t i_error_events,
   input wire logic [LIMIT_W-1:0]          i_register_access_addr,
   input wire logic                        o_register_zone_hit,
   input wire logic [LIMIT_W-1:0]          i_xmem_access_addr,
   input wire logic                        o_xmem_zone_hit,
   input wire ll_debug_pkg::error_events_t o_error_flags
);
   logic [1:0]   tk_ff;
   logic [31:0]  ad_ff;
   zone_limits_t up_ff;
   zone_limits_t lo_ff;
   logic         xin;
   logic         rin;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   assign xin = i_xmem_access_addr >= lo_ff.xmem_zone && i_xmem_access_addr <= up_ff.xmem_zone;
   assign rin = i_register_access_addr >= lo_ff.register_zone &&
                i_register_access_addr <= up_ff.register_zone;
   always_ff @(posedge i_mclk) ad_ff <= i_haddr;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tk_ff <= 2'h0;
         up_ff <= '0;
         lo_ff <= '0;
      end else begin
         // Shadow limits: write lands at end of its data phase
         tk_ff <= {2{i_hsel && i_hready && i_htrans == HTRANS_NONSEQ}} & {i_hwrite, !i_hwrite};
         if (tk_ff[1] && ad_ff == ZONE_UPPER_ADDR) up_ff <= i_hwdata;
         if (tk_ff[1] && ad_ff == ZONE_LOWER_ADDR) lo_ff <= i_hwdata;
      end
   end
   property p_diag; tk_ff[0] && ad_ff == DIAG_MIRROR_ADDR |-> o_hrdata == $past(i_diag_buses); endproperty
   a_diag: assert property (p_diag) else $error("diag read wrong");
   property p_up; tk_ff[0] && ad_ff == ZONE_UPPER_ADDR |-> o_hrdata == $past(up_ff); endproperty
   a_up: assert property (p_up) else $error("upper read wrong");
   property p_lo; tk_ff[0] && ad_ff == ZONE_LOWER_ADDR |-> o_hrdata == $past(lo_ff); endproperty
   a_lo: assert property (p_lo) else $error("lower read wrong");
   property p_xzone; $past(i_nrst) |-> o_xmem_zone_hit == $past(xin); endproperty
   a_xzone: assert property (p_xzone) else $error("zone hit wrong");
   property p_rzone; $past(i_nrst) |-> o_register_zone_hit == $past(rin); endproperty
   a_rzone: assert property (p_rzone) else $error("register zone hit wrong");
   property p_set_hi; |i_error_events[17:9] |=> &(o_error_flags[17:9] | ~$past(i_error_events[17:9])); endproperty
   a_set_hi: assert property (p_set_hi) else $error("flag not set");
   property p_set_lo; |i_error_events[8:0] ##1 1'b1 |-> &(o_error_flags[8:0] | ~$past(i_error_events[8:0])); endproperty
   a_set_lo: assert property (p_set_lo) else $error("flag not set");
   property p_sticky; 1'b1 |-> (o_error_flags & $past(o_error_flags)) == $past(o_error_flags); endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");
   property p_err; tk_ff[0] && ad_ff == ERROR_FLAGS_ADDR |-> o_hrdata == {14'h0, $past(o_error_flags)}; endproperty
   a_err: assert property (p_err) else $error("error read wrong");
endmodule
bind ll_debug_regs ll_debug_regs_sva i_sva (.i_mclk, .i_nrst, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .i_diag_buses, .i_error_events,
   .i_register_access_addr, .o_register_zone_hit,
   .i_xmem_access_addr, .o_xmem_zone_hit, .o_error_flags);

// ### dv/test_link_layer_debug_error_status.sv
// Bench: random register traffic, zone sweeps and error flag pulses.
// Assumes the checker file is compiled with the design.
`timescale 1ns/1ps
module test_link_layer_debug_error_status;
   import ll_debug_pkg::*;
   logic          mclk = 1'b0;
   logic          nrst = 1'b0;
   logic          hsel = 1'b0;
   logic          hwrite = 1'b0;
   logic [1:0]    htrans = 2'h0;
   logic [31:0]   haddr = '0, hwdata = '0, hrdata, q;
   logic          hready, hresp, rhit, xhit;
   diag_buses_t   diag = '0;
   error_events_t ev = '0, acc = '0, flags;
   logic [15:0]   ra = '0, xa = '0;
   zone_limits_t  up, lo;
   int            error_cnt = 0, tests_run = 0, cyc = 0;
   ll_debug_regs i_dut (.i_mclk(mclk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(HSIZE_WORD), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_diag_buses(diag), .i_error_events(ev), .i_register_access_addr(ra),
      .i_xmem_access_addr(xa), .o_register_zone_hit(rhit), .o_xmem_zone_hit(xhit),
      .o_error_flags(flags));
   always #5 mclk = ~mclk;
   task automatic end_sim();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // Both limits and one step past each, then one random address
   function automatic logic [15:0] pick(int k, logic [15:0] l, logic [15:0] h);
      return k == 0 ? l - 16'h1 : k == 1 ? l : k == 2 ? h : k == 3 ? h + 16'h1 : 16'($urandom());
   endfunction
   task automatic zsweep();
      for (int k = 0; k < 5; k++) begin
         ra <= pick(k, lo.register_zone, up.register_zone);
         xa <= pick(k, lo.xmem_zone, up.xmem_zone);
         repeat (2) @(posedge mclk);
         chk("reg zone", 32'(ra >= lo.register_zone && ra <= up.register_zone), 32'(rhit));
         chk("xmem zone", 32'(xa >= lo.xmem_zone && xa <= up.xmem_zone), 32'(xhit));
      end
   endtask
   initial begin
      q = $urandom(32'h2591);
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      hsel <= 1'b1;
      @(posedge mclk);
      // Reset image, unmapped word included
      for (int k = 0; k < 5; k++) begin
         xfer(1'b0, DIAG_MIRROR_ADDR + 32'(4 * k), 32'h0);
         chk("reset value", 32'h0, q);
      end
      up = '0;
      lo = '0;
      zsweep();
      for (int i = NUM_ERR - 1; i >= 0; i--) begin
         ev <= error_events_t'(18'h1 << i);
         acc[i] = 1'b1;
         @(posedge mclk);
         ev <= '0;
         @(posedge mclk);
         chk("flags", 32'(acc), 32'(flags));
         xfer(1'b1, ERROR_FLAGS_ADDR, 32'h0);
         xfer(1'b0, ERROR_FLAGS_ADDR, 32'h0);
         chk("error reg", 32'(acc), q);
         chk("flag bit", 32'h1, 32'(flags[i]));
      end
      repeat (20) begin
         diag <= $urandom();
         up = $urandom();
         lo = $urandom();
         xfer(1'b1, ZONE_UPPER_ADDR, up);
         xfer(1'b1, ZONE_LOWER_ADDR, lo);
         xfer(1'b1, DIAG_MIRROR_ADDR, $urandom());
         xfer(1'b0, ZONE_UPPER_ADDR, 32'h0);
         chk("upper", up, q);
         xfer(1'b0, ZONE_LOWER_ADDR, 32'h0);
         chk("lower", lo, q);
         xfer(1'b0, DIAG_MIRROR_ADDR, 32'h0);
         chk("diag", diag, q);
         zsweep();
      end
      // Only a reset clears the flags
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      chk("flags after reset", 32'h0, 32'(flags));
      end_sim();
   end
endmodule
